// File: hdl/flash_boot_loader.sv
// boot-mode entry, serial rate matching, program loader and ram overlay
`timescale 1ns/1ps

// How it works
// - mode pins at reset release pick boot, user program or normal user mode.
// - boot mode erases all flash blocks when flash is not blank.
// - serial channel is 8 data bits, one stop bit, no parity.
// - low time of received zero bytes sets the serial bit-rate divisor.
// - measurement starts only 100 states after reset completes.
// - after rate match the device sends one zero byte.
// - matching only guaranteed for listed host rates and clock ranges.
// - loaded program bytes go to ram 0xffc000 to 0xffdfff.
// - before branching, clear receive/transmit enables, line high, keep divisor.
// - watchdog overflow also ends boot mode.
// - interrupts are blocked while programming or erasing.
// - flash reads are blocked while programming or erasing.
// - overlay works only in user or user program mode.
// - overlay ram is 4 kbyte at 0xffd000 over one selectable flash block.
// - active overlay answers at ram and selected flash block addresses.
// - overlay enabled protects all blocks; program/erase start is refused.
// - clearing overlay enable restores flash to its own range.
// - erasing an overlaid region never clears the overlay ram.
module flash_boot_loader (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        flashWriteEnablePin,
    input  wire logic        modeSelectPinHi,
    input  wire logic        modeSelectPinLo,
    input  wire logic        watchdogOverflow,
    input  wire logic        rxd,
    output logic             txd,
    input  wire logic        flashBlank,
    input  wire logic        flashEraseDone,
    output logic             flashEraseAll,
    output logic             flashProgram,
    output logic             flashErase,
    output logic             flashReadBlock,
    output logic             irqBlock,
    output logic             bootActive,
    output logic             ramWe,
    output logic [23:0]      ramAddr,
    output logic [7:0]       ramWdata,
    input  wire logic [23:0] cpuAddr,
    output logic [23:0]      memAddr,
    output logic             overlayHit,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o
);

    typedef struct packed {
        flash_boot_pkg::mode_t       mode;
        flash_boot_pkg::boot_state_t boot;
        logic [15:0] waitCnt;
        logic [3:0]  ninth;
        logic [15:0] baudDiv; // spans the slowest matched rate
        logic        overlayEn;
        logic [2:0]  overlayBlk;
        logic        progStart;
        logic        eraseStart;
        logic        rxEn;
        logic        txEn;
        logic        rxBusy;
        logic [15:0] rxCnt;
        logic [3:0]  rxBit;
        logic [7:0]  rxShift;
        logic [7:0]  rxData;
        logic        rxFull;
        logic        txBusy;
        logic [15:0] txCnt;
        logic [3:0]  txBit;
        logic [9:0]  txShift;
        logic        ramWe;
        logic [23:0] ramAddr;
        logic [7:0]  ramWdata;
        logic [23:0] memAddr;
        logic        overlayHit;
        logic [31:0] rdData;
        logic        ack;
    } state_t;
    state_t cur;
    state_t nxt;
    // true when addr lies in [lo, hi]
    function automatic logic inRange(input logic [23:0] addr,
                                     input logic [23:0] lo,
                                     input logic [23:0] hi);
        inRange = (addr >= lo) && (addr <= hi);
    endfunction
    // base address of flash block n, blocks are 4 kbyte long
    function automatic logic [23:0] blockBase(input logic [2:0] n);
        blockBase = 24'({n, 12'h000});
    endfunction
    logic        overlayActive;
    logic        flashBusy;
    logic        wbReq;
    logic        wbWrite;
    logic        rxValid;
    logic [23:0] blkLo;
    logic [23:0] blkHi;
    // overlay is ignored in boot mode
    assign overlayActive = cur.overlayEn &&
        (cur.mode == flash_boot_pkg::MODE_USER ||
         cur.mode == flash_boot_pkg::MODE_USER_PROG);
    assign flashBusy = flashProgram || flashErase || flashEraseAll;
    assign wbReq     = wb_cyc_i && wb_stb_i && !cur.ack;
    assign wbWrite   = wbReq && wb_we_i;
    assign blkLo     = blockBase(cur.overlayBlk);
    assign blkHi     = blkLo | flash_boot_pkg::BLOCK_MASK;
    assign rxValid   = cur.rxBusy && cur.rxCnt == 16'h0000 &&
                       cur.rxBit == 4'h9 && rxd;
    always_comb begin
        nxt = cur;
        nxt.ack = wbReq;
        nxt.ramWe = 1'b0;
        // mode decode, caught one edge after reset release
        if (cur.boot == flash_boot_pkg::BS_PINS) begin
            if (flashWriteEnablePin && modeSelectPinHi && !modeSelectPinLo)
            begin
                nxt.mode = flash_boot_pkg::MODE_BOOT;
                nxt.boot = flash_boot_pkg::BS_BLANK;
            end else begin
                nxt.boot = flash_boot_pkg::BS_OFF;
                if (flashWriteEnablePin && modeSelectPinHi && modeSelectPinLo)
                begin
                    nxt.mode = flash_boot_pkg::MODE_USER_PROG;
                end else if (!flashWriteEnablePin && modeSelectPinHi &&
                             modeSelectPinLo) begin
                    nxt.mode = flash_boot_pkg::MODE_USER;
                end else begin
                    nxt.mode = flash_boot_pkg::MODE_INVALID;
                end
            end
        end
        // receiver, 8N1, sampled mid-bit
        if (!cur.rxBusy) begin
            if (cur.rxEn && !rxd) begin
                nxt.rxBusy = 1'b1;
                nxt.rxCnt = cur.baudDiv >> 1;
                nxt.rxBit = 4'h0;
            end
        end else if (cur.rxCnt != 16'h0000) begin
            nxt.rxCnt = cur.rxCnt - 16'h0001;
        end else begin
            nxt.rxCnt = cur.baudDiv - 16'h0001;
            nxt.rxBit = cur.rxBit + 4'h1;
            if (cur.rxBit == 4'h0 && rxd) begin
                nxt.rxBusy = 1'b0;
            end else if (cur.rxBit != 4'h0 && cur.rxBit != 4'h9) begin
                nxt.rxShift = {rxd, cur.rxShift[7:1]};
            end else if (cur.rxBit == 4'h9) begin
                // a bad stop bit drops the character
                nxt.rxBusy = 1'b0;
            end
        end
        if (rxValid) begin
            nxt.rxData = cur.rxShift;
        end
        // transmitter, 8N1
        if (cur.txBusy) begin
            if (cur.txCnt != 16'h0000) begin
                nxt.txCnt = cur.txCnt - 16'h0001;
            end else begin
                nxt.txCnt = cur.baudDiv - 16'h0001;
                nxt.txShift = {1'b1, cur.txShift[9:1]};
                nxt.txBit = cur.txBit + 4'h1;
                if (cur.txBit == 4'h9) begin
                    nxt.txBusy = 1'b0;
                end
            end
        end
        // ---- boot sequencer
        case (cur.boot)
            flash_boot_pkg::BS_BLANK: begin
                nxt.boot = flashBlank ? flash_boot_pkg::BS_SETTLE
                                      : flash_boot_pkg::BS_ERASE;
                nxt.waitCnt = 16'h0000;
            end
            flash_boot_pkg::BS_ERASE: begin
                if (flashEraseDone) begin
                    nxt.boot = flash_boot_pkg::BS_SETTLE;
                end
            end
            flash_boot_pkg::BS_SETTLE: begin
                // hold off the low-time measurement after reset
                nxt.waitCnt = cur.waitCnt + 16'h0001;
                if (cur.waitCnt >=
                    16'(flash_boot_pkg::READY_STATES - 1)) begin
                    nxt.waitCnt = 16'h0000;
                    nxt.ninth = 4'h0;
                    nxt.boot = flash_boot_pkg::BS_MEASURE;
                end
            end
            flash_boot_pkg::BS_MEASURE: begin
                // the low run of a zero byte is start plus eight data bits,
                // so every ninth low cycle adds one to the divisor
                if (!rxd) begin
                    if (cur.ninth ==
                        4'(flash_boot_pkg::BITS_PER_ZERO - 1)) begin
                        nxt.ninth = 4'h0;
                        nxt.waitCnt = cur.waitCnt + 16'h0001;
                    end else begin
                        nxt.ninth = cur.ninth + 4'h1;
                    end
                end else if (cur.waitCnt != 16'h0000) begin
                    nxt.baudDiv = cur.waitCnt;
                    nxt.boot = flash_boot_pkg::BS_SEND_ZERO;
                end
            end
            flash_boot_pkg::BS_SEND_ZERO: begin
                // send at once when rxd is high (end of the low run) and the transmitter is idle
                if (!cur.txBusy && rxd) begin
                    nxt.txBusy = 1'b1;
                    nxt.txCnt = cur.baudDiv - 16'h0001;
                    nxt.txBit = 4'h0;
                    nxt.txShift = {1'b1, flash_boot_pkg::ZERO_BYTE, 1'b0};
                    nxt.rxEn = 1'b1;
                    nxt.txEn = 1'b1;
                    nxt.boot = flash_boot_pkg::BS_WAIT_SYNC;
                end
            end
            flash_boot_pkg::BS_WAIT_SYNC: begin
                // any other byte is skipped; the host retries by reset
                if (rxValid && cur.rxShift == flash_boot_pkg::SYNC_BYTE) begin
                    nxt.ramAddr = flash_boot_pkg::LOAD_BASE;
                    nxt.boot = flash_boot_pkg::BS_LOAD;
                end
            end
            flash_boot_pkg::BS_LOAD: begin
                if (rxValid && inRange(cur.ramAddr, flash_boot_pkg::LOAD_BASE,
                                       flash_boot_pkg::LOAD_LAST)) begin
                    nxt.ramWe = 1'b1;
                    nxt.ramWdata = cur.rxShift;
                end
                if (cur.ramWe) begin
                    nxt.ramAddr = cur.ramAddr + 24'h000001;
                end
            end
            flash_boot_pkg::BS_PINS, flash_boot_pkg::BS_RUN,
            flash_boot_pkg::BS_OFF: begin
            end
            default: nxt.boot = flash_boot_pkg::BS_OFF;
        endcase
        if (watchdogOverflow && cur.mode == flash_boot_pkg::MODE_BOOT) begin
            nxt.boot = flash_boot_pkg::BS_OFF;
            nxt.mode = flash_boot_pkg::MODE_INVALID;
        end

        // ---- register writes
        if (wbWrite && wb_sel_i[0]) begin
            case (wb_adr_i)
                flash_boot_pkg::OFS_OVERLAY: begin
                    // clearing the enable lifts the overlay at once
                    nxt.overlayEn = wb_dat_i[flash_boot_pkg::OVL_EN_BIT];
                    nxt.overlayBlk =
                        wb_dat_i[flash_boot_pkg::OVL_BLK_LSB +: 3];
                end
                flash_boot_pkg::OFS_FMODE: begin
                    // start bits only take while nothing protects flash
                    nxt.progStart = wb_dat_i[flash_boot_pkg::PROG_BIT] &&
                        !cur.overlayEn &&
                        cur.mode != flash_boot_pkg::MODE_USER &&
                        cur.mode != flash_boot_pkg::MODE_INVALID;
                    nxt.eraseStart = wb_dat_i[flash_boot_pkg::ERASE_BIT] &&
                        !cur.overlayEn &&
                        cur.mode != flash_boot_pkg::MODE_USER &&
                        cur.mode != flash_boot_pkg::MODE_INVALID;
                end
                flash_boot_pkg::OFS_BAUD: begin
                    nxt.baudDiv[7:0] = wb_dat_i[7:0];
                end
                flash_boot_pkg::OFS_SERCTL: begin
                    nxt.rxEn = wb_dat_i[flash_boot_pkg::RX_EN_BIT];
                    nxt.txEn = wb_dat_i[flash_boot_pkg::TX_EN_BIT];
                end
                flash_boot_pkg::OFS_DATA: begin
                    // a write while busy is dropped; poll the busy flag
                    if (cur.txEn && !cur.txBusy) begin
                        nxt.txBusy = 1'b1;
                        nxt.txCnt = cur.baudDiv - 16'h0001;
                        nxt.txBit = 4'h0;
                        nxt.txShift = {1'b1, wb_dat_i[7:0], 1'b0};
                    end
                end
                flash_boot_pkg::OFS_BOOTCTL: begin
                    if (wb_dat_i[flash_boot_pkg::BRANCH_BIT] &&
                        cur.boot == flash_boot_pkg::BS_LOAD) begin
                        // serial stops, line idles high, divisor kept
                        nxt.rxEn = 1'b0;
                        nxt.txEn = 1'b0;
                        nxt.rxBusy = 1'b0;
                        nxt.txBusy = 1'b0;
                        nxt.boot = flash_boot_pkg::BS_RUN;
                    end
                end
                default: ;
            endcase
        end
        if (wbWrite && wb_sel_i[1] &&
            wb_adr_i == flash_boot_pkg::OFS_BAUD) begin
            nxt.baudDiv[15:8] = wb_dat_i[15:8];
        end
        // overlay turned on drops any running program or erase
        if (cur.overlayEn) begin
            nxt.progStart = 1'b0;
            nxt.eraseStart = 1'b0;
        end

        // ---- receive-full flag, a new byte wins over the read that clears
        if (wbReq && !wb_we_i && wb_adr_i == flash_boot_pkg::OFS_DATA) begin
            nxt.rxFull = 1'b0;
        end
        if (rxValid) begin
            nxt.rxFull = 1'b1;
        end

        // ---- register reads
        nxt.rdData = 32'h00000000;
        if (wbReq && !wb_we_i) begin
            case (wb_adr_i)
                flash_boot_pkg::OFS_OVERLAY: begin
                    nxt.rdData[flash_boot_pkg::OVL_EN_BIT] = cur.overlayEn;
                    nxt.rdData[flash_boot_pkg::OVL_BLK_LSB +: 3] =
                        cur.overlayBlk;
                end
                flash_boot_pkg::OFS_FMODE: begin
                    nxt.rdData[flash_boot_pkg::PROG_BIT] = cur.progStart;
                    nxt.rdData[flash_boot_pkg::ERASE_BIT] = cur.eraseStart;
                end
                flash_boot_pkg::OFS_BAUD: nxt.rdData[15:0] = cur.baudDiv;
                flash_boot_pkg::OFS_SERCTL: begin
                    nxt.rdData[flash_boot_pkg::RX_EN_BIT] = cur.rxEn;
                    nxt.rdData[flash_boot_pkg::TX_EN_BIT] = cur.txEn;
                end
                flash_boot_pkg::OFS_STATUS: begin
                    nxt.rdData[1:0] = cur.mode;
                    nxt.rdData[flash_boot_pkg::ST_RXFULL] = cur.rxFull;
                    nxt.rdData[flash_boot_pkg::ST_TXBUSY] = cur.txBusy;
                    nxt.rdData[flash_boot_pkg::ST_BOOT] = bootActive;
                    nxt.rdData[flash_boot_pkg::ST_FLASHBUSY] = flashBusy;
                    nxt.rdData[flash_boot_pkg::ST_STATE_LSB +: 4] = cur.boot;
                end
                flash_boot_pkg::OFS_DATA: nxt.rdData[7:0] = cur.rxData;
                default: ;
            endcase
        end

        // overlay address steering, one cycle of latency
        nxt.overlayHit = overlayActive && inRange(cpuAddr, blkLo, blkHi);
        if (nxt.overlayHit) begin
            nxt.memAddr = flash_boot_pkg::OVL_RAM_BASE |
                          (cpuAddr & flash_boot_pkg::BLOCK_MASK);
        end else begin
            nxt.memAddr = cpuAddr;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cur <= '0;
            cur.mode <= flash_boot_pkg::MODE_INVALID;
            cur.boot <= flash_boot_pkg::BS_PINS;
            cur.baudDiv <= flash_boot_pkg::BAUD_RESET;
            cur.txShift <= 10'h3ff;
        end else begin
            cur <= nxt;
        end
    end

    assign txd = cur.txBusy ? cur.txShift[0] : 1'b1;
    assign bootActive = cur.mode == flash_boot_pkg::MODE_BOOT &&
                        cur.boot != flash_boot_pkg::BS_RUN &&
                        cur.boot != flash_boot_pkg::BS_OFF;
    // erase goes to the flash array only, never to the overlay ram
    assign flashEraseAll = cur.boot == flash_boot_pkg::BS_ERASE;
    assign flashProgram = cur.progStart && !cur.overlayEn;
    assign flashErase = cur.eraseStart && !cur.overlayEn;
    assign flashReadBlock = flashBusy;
    assign irqBlock = flashBusy || bootActive;
    assign ramWe = cur.ramWe;
    assign ramAddr = cur.ramAddr;
    assign ramWdata = cur.ramWdata;
    assign memAddr = cur.memAddr;
    assign overlayHit = cur.overlayHit;
    assign wb_dat_o = cur.rdData;
    assign wb_ack_o = cur.ack;

endmodule

// File: hdl/flash_boot_pkg.sv
// shared constants and types of the flash boot loader and ram overlay
package flash_boot_pkg;
    // register byte offsets on the wishbone slave
    localparam logic [7:0] OFS_OVERLAY = 8'h00;
    localparam logic [7:0] OFS_FMODE   = 8'h04;
    localparam logic [7:0] OFS_BAUD    = 8'h08;
    localparam logic [7:0] OFS_SERCTL  = 8'h0c;
    localparam logic [7:0] OFS_STATUS  = 8'h10;
    localparam logic [7:0] OFS_DATA    = 8'h14;
    localparam logic [7:0] OFS_BOOTCTL = 8'h18;
    // field positions
    localparam int OVL_EN_BIT   = 0;
    localparam int OVL_BLK_LSB  = 1;
    localparam int PROG_BIT     = 0;
    localparam int ERASE_BIT    = 1;
    localparam int RX_EN_BIT    = 0;
    localparam int TX_EN_BIT    = 1;
    localparam int BRANCH_BIT   = 0;
    localparam int ST_RXFULL    = 4;
    localparam int ST_TXBUSY    = 5;
    localparam int ST_BOOT      = 6;
    localparam int ST_FLASHBUSY = 7;
    localparam int ST_STATE_LSB = 8;
    // reset values
    localparam logic [15:0] BAUD_RESET = 16'h0000;
    // timing in states (one state is one clk_sys cycle)
    localparam int READY_STATES = 100;
    localparam int BITS_PER_ZERO = 9;
    // boot character values
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] SYNC_BYTE = 8'h55;
    // address map
    localparam logic [23:0] LOAD_BASE    = 24'hffc000;
    localparam logic [23:0] LOAD_LAST    = 24'hffdfff;
    localparam logic [23:0] OVL_RAM_BASE = 24'hffd000;
    localparam logic [23:0] BLOCK_MASK   = 24'h000fff;
    localparam int          BLOCK_SHIFT  = 12;
    localparam int          BLOCK_COUNT  = 8;

    typedef enum logic [1:0] {
        MODE_BOOT, MODE_USER_PROG, MODE_USER, MODE_INVALID
    } mode_t;

    typedef enum logic [3:0] {
        BS_PINS, BS_BLANK, BS_ERASE, BS_SETTLE, BS_MEASURE, BS_SEND_ZERO,
        BS_WAIT_SYNC, BS_LOAD, BS_RUN, BS_OFF
    } boot_state_t;
endpackage

// File: verification/flash_boot_loader_asserts.sv
// port assertions for the boot loader
`timescale 1ns/1ps
module flash_boot_loader_asserts (
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic        flashWriteEnablePin,
    input wire logic        modeSelectPinHi,
    input wire logic        modeSelectPinLo,
    input wire logic        watchdogOverflow,
    input wire logic        flashReadBlock,
    input wire logic        irqBlock,
    input wire logic        bootActive,
    input wire logic        ramWe,
    input wire logic [23:0] ramAddr,
    input wire logic [23:0] cpuAddr,
    input wire logic [23:0] memAddr,
    input wire logic        overlayHit
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    property p_mode; $rose(rst_b) |=> bootActive == (flashWriteEnablePin
        && modeSelectPinHi && !modeSelectPinLo); endproperty
    a_mode: assert property (p_mode)
        else $error("boot flag wrong after reset");
    property p_irq; flashReadBlock || bootActive |-> irqBlock; endproperty
    a_irq: assert property (p_irq)
        else $error("interrupts not blocked");
    property p_hitHi; overlayHit |-> memAddr[23:12] == 12'hffd; endproperty
    a_hitHi: assert property (p_hitHi)
        else $error("overlay outside ram window");
    property p_hitLo; overlayHit |->
        ((memAddr ^ $past(cpuAddr)) & 24'h000fff) == 24'h0; endproperty
    a_hitLo: assert property (p_hitLo)
        else $error("overlay offset lost");
    property p_pass; $past(rst_b) && !overlayHit |->
        memAddr == $past(cpuAddr); endproperty
    a_pass: assert property (p_pass)
        else $error("flash address not passed through");
    property p_win; ramWe |-> ramAddr[23:13] == 11'h7fe; endproperty
    a_win: assert property (p_win)
        else $error("load write outside window");
    property p_step; ramWe |=> ramAddr == $past(ramAddr) + 24'h1; endproperty
    a_step: assert property (p_step)
        else $error("load address did not step");
    property p_wdt; watchdogOverflow |-> ##[1:2] !bootActive; endproperty
    a_wdt: assert property (p_wdt)
        else $error("watchdog did not end boot");
endmodule

bind flash_boot_loader flash_boot_loader_asserts u_asserts (
    .clk_sys(clk_sys), .rst_b(rst_b), .watchdogOverflow(watchdogOverflow),
    .flashWriteEnablePin(flashWriteEnablePin),
    .modeSelectPinHi(modeSelectPinHi), .modeSelectPinLo(modeSelectPinLo),
    .flashReadBlock(flashReadBlock), .irqBlock(irqBlock),
    .bootActive(bootActive), .ramWe(ramWe), .ramAddr(ramAddr),
    .cpuAddr(cpuAddr), .memAddr(memAddr), .overlayHit(overlayHit)
);

// File: verification/host_serial_model.sv
// host computer model on the boot serial link
`timescale 1ns/1ps
module host_serial_model #(
    parameter int BIT = 1042 // 19200 bps at 20 MHz
) (
    input  wire logic  clk_sys,
    input  wire logic  go,
    input  wire logic  txd,
    output logic       rxd,
    output logic [7:0] reply,
    output logic       finished
);
    logic gotStart;
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd <= f[i]; // 8N1, lsb first
            repeat (BIT) @(posedge clk_sys);
        end
    endtask
    initial begin
        rxd = 1'b1; // idle high through reset end, as a pull-up would
        reply = 8'hff;
        finished = 1'b0;
        gotStart = 1'b0;
        wait (go === 1'b1);
        @(posedge clk_sys);
        fork
            while (!gotStart) send(8'h00); // zeros back to back
            begin
                while (txd !== 1'b0) @(posedge clk_sys);
                gotStart = 1'b1;
                repeat (BIT / 2) @(posedge clk_sys);
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT) @(posedge clk_sys);
                    reply[i] = txd;
                end
                repeat (BIT) @(posedge clk_sys);
            end
        join
        send(8'h55);
        send(8'ha5);
        send(8'h3c);
        finished <= 1'b1;
    end
endmodule

// File: verification/testbench.sv
// bench for the flash boot loader and ram overlay
`timescale 1ns/1ps
module testbench;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic [2:0]  pins = 3'b011;
    logic        watchdogOverflow = 1'b0;
    logic        flashBlank = 1'b1;
    logic        flashEraseDone = 1'b0;
    logic        go = 1'b0;
    logic [2:0]  req = 3'b000;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [23:0] cpuAddr = 24'h0;
    logic        rxd, txd, flashEraseAll, flashProgram, flashErase, finished;
    logic        flashReadBlock, irqBlock, bootActive, ramWe, hit, ack;
    logic [23:0] ramAddr, memAddr;
    logic [7:0]  ramWdata, reply;
    logic [31:0] dato, rdat;
    int          fails = 0;
    int          checkCount = 0;
    logic [31:0] loaded [$];
    always #25 clk_sys = ~clk_sys;
    flash_boot_loader dut (.clk_sys(clk_sys), .rst_b(rst_b),
        .flashWriteEnablePin(pins[2]), .modeSelectPinHi(pins[1]),
        .modeSelectPinLo(pins[0]), .watchdogOverflow(watchdogOverflow),
        .rxd(rxd), .txd(txd), .flashBlank(flashBlank),
        .flashEraseDone(flashEraseDone), .flashEraseAll(flashEraseAll),
        .flashProgram(flashProgram), .flashErase(flashErase),
        .flashReadBlock(flashReadBlock), .irqBlock(irqBlock),
        .bootActive(bootActive), .ramWe(ramWe), .ramAddr(ramAddr),
        .ramWdata(ramWdata), .cpuAddr(cpuAddr), .memAddr(memAddr),
        .overlayHit(hit), .wb_cyc_i(req[2]), .wb_stb_i(req[1]),
        .wb_we_i(req[0]), .wb_adr_i(adr), .wb_sel_i(4'h3),
        .wb_dat_i(wdat), .wb_dat_o(dato), .wb_ack_o(ack));
    host_serial_model #(.BIT(1042)) host (.clk_sys(clk_sys), .go(go),
        .txd(txd), .rxd(rxd), .reply(reply), .finished(finished));
    always @(posedge clk_sys)
        if (ramWe === 1'b1) loaded.push_back({ramAddr, ramWdata});
    task automatic testDone();
        $display("checks %0d mismatches %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic hang();
        fails++;
        $display("mismatch at %0t: wait timed out", $time);
        testDone();
    endtask
    // one classic cycle; ack is taken at the edge it is sampled high
    task automatic bus(input logic w, input logic [7:0] a, logic [31:0] d);
        @(posedge clk_sys);
        {req, adr, wdat} <= {2'b11, w, a, d};
        for (int i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            if (ack === 1'b1) break;
            if (i == 19) hang();
        end
        rdat = dato;
        req <= 3'b000;
    endtask
    task automatic resetTo(input logic [2:0] p, input int n);
        @(posedge clk_sys);
        rst_b <= 1'b0;
        pins <= p;
        repeat (n) @(posedge clk_sys);
        rst_b <= 1'b1;
    endtask
    task automatic waitHigh(input int sel, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            if ((sel == 0 ? flashEraseAll : finished) === 1'b1) break;
            if (i == n - 1) hang();
        end
        checkCount++;
    endtask
    task automatic probe(input logic [23:0] a, input logic [24:0] e);
        cpuAddr <= a;
        repeat (2) @(posedge clk_sys);
        compare({hit, memAddr}, e);
    endtask
    task automatic testModes();
        logic [2:0] p [4] = '{3'b110, 3'b111, 3'b011, 3'b000};
        for (int i = 0; i < 4; i++) begin
            resetTo(p[i], 20);
            bus(1'b0, flash_boot_pkg::OFS_STATUS, 32'h0);
            compare({rdat[1:0], bootActive}, {i[1:0], i == 0});
        end
    endtask
    task automatic testOverlay();
        bus(1'b1, flash_boot_pkg::OFS_OVERLAY, 32'h5);
        probe(24'h002345, {1'b1, 24'hffd345});
        probe(24'hffd010, {1'b0, 24'hffd010});
        probe(24'h003000, {1'b0, 24'h003000});
        bus(1'b1, flash_boot_pkg::OFS_FMODE, 32'h3);
        bus(1'b0, flash_boot_pkg::OFS_FMODE, 32'h0);
        compare({rdat[1:0], flashProgram, flashErase}, 4'h0);
        bus(1'b1, flash_boot_pkg::OFS_OVERLAY, 32'h0);
        probe(24'h002345, {1'b0, 24'h002345});
        bus(1'b1, flash_boot_pkg::OFS_FMODE, 32'h1);
        compare({flashProgram, flashReadBlock, irqBlock}, 3'h7);
        bus(1'b0, 8'h40, 32'h0);
        compare(rdat, 32'h0);
    endtask
    task automatic testWatchdog();
        resetTo(3'b110, 20);
        bus(1'b1, flash_boot_pkg::OFS_OVERLAY, 32'h5);
        probe(24'h002345, {1'b0, 24'h002345});
        watchdogOverflow <= 1'b1;
        @(posedge clk_sys);
        watchdogOverflow <= 1'b0;
        bus(1'b0, flash_boot_pkg::OFS_STATUS, 32'h0);
        compare({rdat[1:0], bootActive}, 3'b110);
    endtask
    task automatic testBoot();
        flashBlank <= 1'b0;
        resetTo(3'b110, 20);
        waitHigh(0, 10);
        flashEraseDone <= 1'b1;
        @(posedge clk_sys);
        flashEraseDone <= 1'b0;
        repeat (120) @(posedge clk_sys); // host waits past settle
        go <= 1'b1;
        waitHigh(1, 90000);
        repeat (4) @(posedge clk_sys);
        compare(reply, 32'h0);
        compare(loaded.size(), 32'h2);
        compare(loaded[0], 32'hffc000a5);
        compare(loaded[1], 32'hffc0013c);
        bus(1'b0, flash_boot_pkg::OFS_BAUD, 32'h0);
        compare(rdat[15:0], 16'h0412);
        bus(1'b1, flash_boot_pkg::OFS_BOOTCTL, 32'h1);
        bus(1'b0, flash_boot_pkg::OFS_SERCTL, 32'h0);
        compare({rdat[1:0], txd, bootActive}, 4'h2);
        bus(1'b0, flash_boot_pkg::OFS_BAUD, 32'h0);
        compare(rdat[15:0], 16'h0412);
    endtask
    initial begin
        resetTo(3'b111, 2);
        testOverlay();
        testModes();
        testWatchdog();
        testBoot();
        testDone();
    end
endmodule
